// ===== rtl/sccr_top.sv
// sccr_top: startup clock and reset control with reset pin and test port.
// assumes straps, reset and test pins are asynchronous and are synchronised here.
module sccr_top #(
    parameter int unsigned LOCK_CNT = sccr_pkg::LOCK_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic reset_n_i,
    input wire logic [1:0] ratio_strap_i,
    input wire logic [2:0] boot_strap_i,
    input wire logic pmc_wr_i,
    input wire logic [5:0] pmc_ratio_i,
    input wire logic [7:0] runrst_ctl_i,
    input wire logic rstpin_i,
    output logic rstpin_o,
    output logic rstpin_oe_o,
    input wire logic test_rst_n_i,
    input wire logic test_clk_i,
    input wire logic test_mode_i,
    input wire logic test_data_i,
    output logic test_data_o,
    output logic test_data_oe_o,
    output logic core_rst_o,
    output logic core_run_o,
    output logic fetch_vector_o,
    output logic [5:0] core_ratio_o,
    output logic ratio_reserved_o,
    output logic [2:0] boot_mode_o
);
    import sccr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for every pin input
    logic [8:0] sync1_q;
    logic [8:0] sync2_q;
    always_ff @(posedge sys_clk_i)
    begin
        sync1_q <= {reset_n_i, ratio_strap_i, boot_strap_i, rstpin_i, test_rst_n_i, test_clk_i};
        sync2_q <= sync1_q;
    end
    logic [1:0] tms_tdi_s1_q;
    logic [1:0] tms_tdi_s2_q;
    always_ff @(posedge sys_clk_i)
    begin
        tms_tdi_s1_q <= {test_mode_i, test_data_i};
        tms_tdi_s2_q <= tms_tdi_s1_q;
    end
    wire logic rst_n_s = sync2_q[8];
    wire logic [1:0] ratio_s = sync2_q[7:6];
    wire logic [2:0] boot_s = sync2_q[5:3];
    wire logic rstpin_s = sync2_q[2];
    wire logic trst_n_s = sync2_q[1];
    wire logic tck_s = sync2_q[0];
    wire logic tms_s = tms_tdi_s2_q[1];
    wire logic tdi_s = tms_tdi_s2_q[0];

    ////////////////////////////////////////////////////////////////////////
    // running reset input only counts once software enabled the pin function
    logic runrst_en;
    assign runrst_en = runrst_ctl_i[RUNRST_EN_BIT];
    logic hold_rst;
    assign hold_rst = !rst_n_s || (runrst_en && !rstpin_s);

    sccr_state_t state_q;
    logic [12:0] lock_cnt_q;
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || hold_rst)
        begin
            state_q <= SCCR_HOLD;
            lock_cnt_q <= '0;
        end
        else
        begin
            unique case (state_q)
                SCCR_HOLD:
                begin
                    state_q <= SCCR_LOCK;
                    lock_cnt_q <= '0;
                end
                SCCR_LOCK:
                begin
                    if (lock_cnt_q == 13'(LOCK_CNT - 1))
                        state_q <= SCCR_RUN;
                    lock_cnt_q <= lock_cnt_q + 13'h0001;
                end
                SCCR_RUN:
                    state_q <= SCCR_RUN;
            endcase
        end
    end

    logic fetch_q;
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || hold_rst)
            fetch_q <= 1'b0;
        else
            fetch_q <= (state_q == SCCR_LOCK) && (lock_cnt_q == 13'(LOCK_CNT - 1));
    end
    assign fetch_vector_o = fetch_q;
    assign core_run_o = (state_q == SCCR_RUN);
    assign core_rst_o = (state_q != SCCR_RUN);

    ////////////////////////////////////////////////////////////////////////
    // strap capture on the release cycle; a later strap change is ignored
    logic [5:0] ratio_q;
    logic resv_q;
    logic [2:0] boot_q;
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || hold_rst)
        begin
            ratio_q <= RATIO_RST;
            resv_q <= 1'b0;
            boot_q <= BOOT_CFG_RST;
        end
        else if (state_q == SCCR_HOLD)
        begin
            boot_q <= boot_s;
            resv_q <= 1'b0;
            unique case (ratio_s)
                RATIO_CODE_8: ratio_q <= RATIO_VAL_8;
                RATIO_CODE_32: ratio_q <= RATIO_VAL_32;
                RATIO_CODE_16: ratio_q <= RATIO_VAL_16;
                default:
                begin
                    ratio_q <= RATIO_VAL_8;
                    resv_q <= 1'b1;
                end
            endcase
        end
        else if (pmc_wr_i && state_q == SCCR_RUN)
            ratio_q <= pmc_ratio_i;
    end
    assign core_ratio_o = ratio_q;
    assign ratio_reserved_o = resv_q;
    assign boot_mode_o = boot_q;

    ////////////////////////////////////////////////////////////////////////
    // combined reset pin: drives low while core held, input when enabled
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            rstpin_o <= 1'b0;
            rstpin_oe_o <= 1'b1;
        end
        else
        begin
            rstpin_oe_o <= !runrst_en;
            rstpin_o <= (state_q == SCCR_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // simplified test port, stepped on sampled test clock rising edges
    logic tck_d_q;
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            tck_d_q <= 1'b0;
        else
            tck_d_q <= tck_s;
    end
    logic tck_rise;
    assign tck_rise = tck_s && !tck_d_q;

    sccr_tap_t tap_q;
    logic tdo_q;
    logic tdo_oe_q;
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || !trst_n_s)
            tap_q <= SCCR_TAP_RESET;
        else if (tck_rise)
        begin
            unique case (tap_q)
                SCCR_TAP_RESET: tap_q <= tms_s ? SCCR_TAP_RESET : SCCR_TAP_IDLE;
                SCCR_TAP_IDLE: tap_q <= tms_s ? SCCR_TAP_SELECT : SCCR_TAP_IDLE;
                SCCR_TAP_SELECT: tap_q <= tms_s ? SCCR_TAP_RESET : SCCR_TAP_CAPTURE;
                SCCR_TAP_CAPTURE: tap_q <= tms_s ? SCCR_TAP_EXIT : SCCR_TAP_SHIFT;
                SCCR_TAP_SHIFT: tap_q <= tms_s ? SCCR_TAP_EXIT : SCCR_TAP_SHIFT;
                SCCR_TAP_EXIT: tap_q <= tms_s ? SCCR_TAP_UPDATE : SCCR_TAP_SHIFT;
                SCCR_TAP_UPDATE: tap_q <= tms_s ? SCCR_TAP_SELECT : SCCR_TAP_IDLE;
                default: tap_q <= SCCR_TAP_RESET;
            endcase
        end
    end

    // scan path stands in as a one-bit bypass stage
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || !trst_n_s || hold_rst)
        begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end
        else
        begin
            if (tck_rise && tap_q == SCCR_TAP_SHIFT)
                tdo_q <= tdi_s;
            tdo_oe_q <= (tap_q == SCCR_TAP_SHIFT) && (state_q == SCCR_RUN);
        end
    end
    assign test_data_o = tdo_q;
    assign test_data_oe_o = tdo_oe_q;

    ////////////////////////////////////////////////////////////////////////
    property p_lock_wait;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(core_run_o) |-> $past(state_q) == SCCR_LOCK && $past(lock_cnt_q) == 13'(LOCK_CNT - 1);
    endproperty
    a_lock_wait: assert property (p_lock_wait) else $error("core ran before lock wait");

    property p_fetch;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(core_run_o) |-> fetch_vector_o ##1 !fetch_vector_o;
    endproperty
    a_fetch: assert property (p_fetch) else $error("vector fetch not one pulse at start");

    property p_hold;
        @(posedge sys_clk_i) disable iff (rst_i)
        hold_rst |=> core_rst_o && !core_run_o && !tdo_oe_q;
    endproperty
    a_hold: assert property (p_hold) else $error("state not reset while held");

    property p_ratio;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_q == SCCR_HOLD && !hold_rst && ratio_s == RATIO_CODE_32) |=> core_ratio_o == RATIO_VAL_32;
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio strap decode wrong");

    property p_strap_hold;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_q == SCCR_LOCK && !hold_rst) |=> $stable(boot_mode_o);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("boot strap changed after capture");

    property p_pmc;
        @(posedge sys_clk_i) disable iff (rst_i)
        (pmc_wr_i && core_run_o && !hold_rst) |=> core_ratio_o == $past(pmc_ratio_i);
    endproperty
    a_pmc: assert property (p_pmc) else $error("ratio write ignored");

    property p_pin_dir;
        @(posedge sys_clk_i) disable iff (rst_i)
        ##1 rstpin_oe_o == !$past(runrst_en);
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("reset pin direction wrong");

    property p_tap_rst;
        @(posedge sys_clk_i) disable iff (rst_i)
        !trst_n_s |=> tap_q == SCCR_TAP_RESET;
    endproperty
    a_tap_rst: assert property (p_tap_rst) else $error("tap not reset");
endmodule

// ===== pkg/sccr_pkg.sv
// sccr_pkg: constants for the startup clock and reset control block.
// assumes one system clock at 40 MHz standing in for the input clock.
package sccr_pkg;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned LOCK_WAIT_INPUT_CYCLES = 4096;
    localparam int unsigned LOCK_CYCLES = LOCK_WAIT_INPUT_CYCLES;
    localparam logic [1:0] RATIO_CODE_8 = 2'h0;
    localparam logic [1:0] RATIO_CODE_32 = 2'h1;
    localparam logic [1:0] RATIO_CODE_16 = 2'h2;
    localparam logic [5:0] RATIO_VAL_8 = 6'h08;
    localparam logic [5:0] RATIO_VAL_16 = 6'h10;
    localparam logic [5:0] RATIO_VAL_32 = 6'h20;
    localparam logic [5:0] RATIO_RST = 6'h08;
    localparam logic [2:0] BOOT_CFG_RST = 3'h0;
    localparam int unsigned RUNRST_EN_BIT = 0;
    typedef enum logic [1:0] {
        SCCR_HOLD,
        SCCR_LOCK,
        SCCR_RUN
    } sccr_state_t;
    typedef enum logic [2:0] {
        SCCR_TAP_RESET,
        SCCR_TAP_IDLE,
        SCCR_TAP_SELECT,
        SCCR_TAP_CAPTURE,
        SCCR_TAP_SHIFT,
        SCCR_TAP_EXIT,
        SCCR_TAP_UPDATE
    } sccr_tap_t;
endpackage

// ===== dv/sccr_board.sv
// sccr_board: board side model, reset source, straps, combined pin, test pins.
// assumes its tasks are called just after a rising clock edge.
module sccr_board (
    input wire logic sys_clk_i,
    output logic reset_n_o,
    output logic [1:0] ratio_strap_o,
    output logic [2:0] boot_strap_o,
    output logic pin_low_o,
    output logic test_rst_n_o,
    output logic test_clk_o,
    output logic test_mode_o,
    output logic test_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        reset_n_o = 1'b0;
        ratio_strap_o = 2'h0;
        boot_strap_o = 3'h0;
        pin_low_o = 1'b0;
        test_rst_n_o = 1'b0;
        test_clk_o = 1'b0;
        test_mode_o = 1'b0;
        test_data_o = 1'b0;
    end
    // straps settle well before the release edge, never with it
    task automatic press(input logic [1:0] r, input logic [2:0] b);
        reset_n_o = 1'b0;
        ratio_strap_o = r;
        boot_strap_o = b;
        repeat (5) @(posedge sys_clk_i);
        #2 reset_n_o = 1'b1;
    endtask
    task automatic scramble();
        ratio_strap_o = ~ratio_strap_o;
        boot_strap_o = ~boot_strap_o;
    endtask
    // one slow test clock period; each level spans three system clocks so the synchroniser sees it
    task automatic tap_step(input logic m, input logic d);
        test_mode_o = m;
        test_data_o = d;
        repeat (3) @(posedge sys_clk_i);
        #2 test_clk_o = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #2 test_clk_o = 1'b0;
    endtask
endmodule

// ===== dv/sccr_top_tb.sv
// sccr_top_tb: self-checking bench for startup clock and reset control.
// assumes sccr_board drives the far side; lock count shortened to 16.
module sccr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sccr_pkg::*;
    localparam int LOCK = 16;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, pmc_wr_i = 1'b0;
    logic [5:0] pmc_ratio_i = 6'h00;
    logic [7:0] runrst_ctl_i = 8'h00;
    logic reset_n, pin_low, trst_n, tck, tms, tdi, pin_lvl, rstpin_o, rstpin_oe_o, tdo, tdo_oe;
    logic core_rst_o, core_run_o, fetch_vector_o, ratio_reserved_o;
    logic [1:0] ratio_strap;
    logic [2:0] boot_strap, boot_mode_o;
    logic [5:0] core_ratio_o;
    int num_errors = 0, checks = 0, n;
    always #12.5 sys_clk_i = ~sys_clk_i;
    // released pin floats to the internal pull-up level
    assign pin_lvl = rstpin_oe_o ? rstpin_o : !pin_low;
    sccr_board u_sccr_board (.sys_clk_i(sys_clk_i), .reset_n_o(reset_n), .ratio_strap_o(ratio_strap),
        .boot_strap_o(boot_strap), .pin_low_o(pin_low), .test_rst_n_o(trst_n), .test_clk_o(tck),
        .test_mode_o(tms), .test_data_o(tdi));
    sccr_top #(.LOCK_CNT(LOCK)) u_sccr_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reset_n_i(reset_n),
        .ratio_strap_i(ratio_strap), .boot_strap_i(boot_strap), .pmc_wr_i(pmc_wr_i),
        .pmc_ratio_i(pmc_ratio_i), .runrst_ctl_i(runrst_ctl_i), .rstpin_i(pin_lvl), .rstpin_o(rstpin_o),
        .rstpin_oe_o(rstpin_oe_o), .test_rst_n_i(trst_n), .test_clk_i(tck), .test_mode_i(tms),
        .test_data_i(tdi), .test_data_o(tdo), .test_data_oe_o(tdo_oe), .core_rst_o(core_rst_o),
        .core_run_o(core_run_o), .fetch_vector_o(fetch_vector_o), .core_ratio_o(core_ratio_o),
        .ratio_reserved_o(ratio_reserved_o), .boot_mode_o(boot_mode_o));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk_vec(input logic [5:0] e, input logic [5:0] a);
        checks++;
        if (a !== e)
        begin
            num_errors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
        #2;
    endtask
    // counts cycles from the call until the core runs; bounded
    task automatic wait_run();
        n = 0;
        while (core_run_o !== 1'b1)
        begin
            cyc(1);
            n++;
            if (n > LOCK + 40)
            begin
                num_errors++;
                results();
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic boot(input logic [1:0] r, input logic [2:0] b, input logic [5:0] er, input logic res);
        u_sccr_board.press(r, b);
        cyc(3);
        chk_vec(6'h01, {5'h00, core_rst_o});
        u_sccr_board.scramble();
        wait_run();
        chk_vec(6'h01, {5'h00, n >= LOCK && n <= LOCK + 6});
        chk_vec(6'h03, {4'h0, fetch_vector_o, !core_rst_o});
        chk_vec(er, core_ratio_o);
        chk_vec({5'h00, res}, {5'h00, ratio_reserved_o});
        chk_vec({3'h0, b}, {3'h0, boot_mode_o});
        cyc(1);
        chk_vec(6'h00, {5'h00, fetch_vector_o});
    endtask
    task automatic pmc_test();
        u_sccr_board.press(RATIO_CODE_8, 3'h2);
        cyc(3);
        pmc_wr_i = 1'b1;
        pmc_ratio_i = 6'h0c;
        cyc(1);
        pmc_wr_i = 1'b0;
        wait_run();
        chk_vec(RATIO_VAL_8, core_ratio_o);
        pmc_wr_i = 1'b1;
        cyc(1);
        chk_vec(6'h0c, core_ratio_o);
        pmc_ratio_i = 6'h18;
        cyc(1);
        pmc_wr_i = 1'b0;
        cyc(2);
        chk_vec(6'h18, core_ratio_o);
    endtask
    task automatic runrst_test();
        chk_vec(6'h03, {4'h0, rstpin_oe_o, rstpin_o});
        runrst_ctl_i = 8'h01;
        cyc(2);
        chk_vec(6'h00, {5'h00, rstpin_oe_o});
        u_sccr_board.pin_low_o = 1'b1;
        cyc(5);
        chk_vec(6'h02, {4'h0, core_rst_o, core_run_o});
        u_sccr_board.pin_low_o = 1'b0;
        wait_run();
        chk_vec(6'h01, {5'h00, n <= LOCK + 8});
        runrst_ctl_i = 8'h00;
        cyc(2);
        chk_vec(6'h02, {4'h0, rstpin_oe_o, tdo_oe});
    endtask
    // walks the test port into shift and back out by driving test reset low
    task automatic tap_test();
        u_sccr_board.test_rst_n_o = 1'b1;
        cyc(3);
        u_sccr_board.tap_step(1'b0, 1'b0);
        u_sccr_board.tap_step(1'b1, 1'b0);
        u_sccr_board.tap_step(1'b0, 1'b0);
        cyc(1);
        chk_vec(6'h00, {5'h00, tdo_oe});
        u_sccr_board.tap_step(1'b0, 1'b1);
        cyc(1);
        chk_vec(6'h02, {4'h0, tdo_oe, tdo});
        u_sccr_board.tap_step(1'b0, 1'b1);
        chk_vec(6'h03, {4'h0, tdo_oe, tdo});
        u_sccr_board.tap_step(1'b0, 1'b0);
        chk_vec(6'h02, {4'h0, tdo_oe, tdo});
        u_sccr_board.test_rst_n_o = 1'b0;
        cyc(4);
        chk_vec(6'h00, {4'h0, tdo_oe, tdo});
    endtask
    initial
    begin
        cyc(6);
        chk_vec(6'h05, {3'h0, rstpin_oe_o, tdo_oe, core_rst_o});
        rst_i = 1'b0;
        boot(RATIO_CODE_8, 3'h5, RATIO_VAL_8, 1'b0);
        boot(RATIO_CODE_32, 3'h3, RATIO_VAL_32, 1'b0);
        boot(RATIO_CODE_16, 3'h6, RATIO_VAL_16, 1'b0);
        boot(2'h3, 3'h1, RATIO_VAL_8, 1'b1);
        pmc_test();
        runrst_test();
        tap_test();
        results();
    end
endmodule
